// file: rtl/gpio_sel_consts.svh
// Purpose: Offsets, field positions and reset values of the pin select block.
// Assumes: Register indices are word indices; the byte address is four times the index.
// Notes:   Included by the block and its bench.
`ifndef GPIO_SEL_CONSTS_SVH
`define GPIO_SEL_CONSTS_SVH
// Register word indices.
`define IDX_PIN0_PIN1      10'h023
`define IDX_PIN2_PIN3      10'h024
`define IDX_PIN_LEVELS     10'h025
`define IDX_SYNC_STAMP     10'h026
`define IDX_SLOT_FLAGS     10'h030
`define IDX_STAMP_REQUEST  10'h031
`define IDX_PIN_DIRECTION  10'h032
// Field positions.
`define SEL_LO_MSB         6
`define SEL_HI_LSB         8
`define SEL_HI_MSB         14
`define FLD_IDLE_LEVEL     8
`define FLD_EDGE_INVERT    7
`define FLD_ALWAYS_ARMED   6
`define FLD_STAMP_PIN_LSB  4
`define FLD_SYNC_ENABLE    2
`define FLD_SYNC_PIN_LSB   0
// Output select codes with a fixed meaning.
`define CODE_LOW           7'h00
`define CODE_HIGH          7'h01
`define CODE_INT_X         7'h02
`define CODE_INT_Y         7'h03
`define CODE_ANY_AMP       7'h0C
`define CODE_OSC_DIV64     7'h0F
`define CODE_SLOT_PATTERN  7'h10
`define CODE_SLEEP         7'h11
`define CODE_LOW_OSC       7'h16
`define CODE_OSC_FULL      7'h17
`define CODE_OSC_DIV32     7'h18
`define GROUP_SLOT_ACTIVE  3'h2
`define GROUP_LED_PULSE    3'h3
`define GROUP_MOD_PULSE    3'h4
`define GROUP_DATA_CYCLE   3'h5
`define GROUP_AMP          4'h1
`define SLOT_ANY           4'hF
// Reset values and bus answers.
`define RST_SELECT         7'h00
`define RST_DIRECTION      8'h00
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2
`endif

// file: rtl/gpio_sel_pkg.sv
// Purpose: Types shared by the pin select block and its bench.
// Assumes: Twelve time slots and four pins.
// Notes:   All block state travels as one packed struct.
package gpio_sel_pkg;
    typedef struct packed {
        logic        awvalid;
        logic [11:0] awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [11:0] araddr;
        logic        rready;
    } axil_req_t;
    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } axil_rsp_t;
    // Per-slot activity from the time slot engine, bit n is slot A plus n.
    typedef struct packed {
        logic [11:0] active;
        logic [11:0] led_pulse;
        logic [11:0] mod_pulse;
        logic [11:0] data_cycle;
    } slot_sig_t;
    typedef struct packed {
        logic [3:0][6:0] pin_output_source;
        logic            slot_idle_level;
        logic            stamp_edge_invert;
        logic            stamp_always_armed;
        logic [1:0]      stamp_pin_select;
        logic            outside_trigger_enable;
        logic [1:0]      outside_trigger_pin_select;
        logic [11:0]     per_slot_pin_flag;
        logic            stamp_capture_request;
        logic [7:0]      pin_direction;
        logic [3:0]      pin_drive;
        logic [3:0]      pin_prev;
        logic            stamp_capture;
        logic            sample_start;
        logic            aw_held;
        logic [9:0]      aw_index;
        logic            w_held;
        logic [31:0]     w_data;
        logic [3:0]      w_strb;
        logic            bvalid;
        logic [1:0]      bresp;
        logic            rvalid;
        logic [31:0]     rdata;
        logic [1:0]      rresp;
    } state_t;
endpackage

// file: rtl/gpio_sel_top.sv
// Purpose: Pin output source select, pin readback, time stamp and outside trigger pins.
// Assumes: Pin and slot inputs are synchronous to clk; AXI4-Lite register access.
// Notes:   Pin outputs lag their source by one clock since they come from flip-flops.
// Overview of operation
// - Codes 0x4A and 0x4B give the slot K or L modulation pulse, 0x4F that of any slot.
// - Codes 0x50 to 0x5B mark an output data cycle of slot A to slot L in turn.
// - Code 0x5F marks an output data cycle in any of the twelve slots.
// - Pin 0 takes its source from bits 6 to 0 of the pin 0/1 register, with the full code set.
// - Pin 3 takes its source from bits 14 to 8 of register 0x0024; bit 15 reads zero.
// - Pin 2 takes its source from bits 6 to 0 of register 0x0024; bit 7 reads zero.
// - Register 0x0025 bits 3 to 0 read the level of each input-enabled pin, upper bits zero.
// - Code 0x10 drives the slot idle level at the end of each slot and throughout sleep.
// - The edge invert bit picks a rising (0) or falling (1) time stamp trigger edge.
// - With always armed set, a capture leaves the capture request set.
// - The time stamp pin field picks pin 0 to 3 as trigger input, pin 0 after reset.
// - With outside trigger enabled, the selected pin starts sample sequences, not the period.
// - The outside trigger pin field picks pin 0 to 3 as sample trigger input.
// - Codes 0x00 and 0x01 drive low and high; 0x02 and 0x03 route interrupts X and Y.
// - Code 0x10 drives one while any flagged slot is active outside sleep, then the idle level.
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/10ps
`include "gpio_sel_consts.svh"
`default_nettype none
module gpio_sel_top (
    // Clock and reset.
    input  wire logic                   clk,
    input  wire logic                   reset_n,
    // Register bus.
    input  wire gpio_sel_pkg::axil_req_t bus_req,
    output var  gpio_sel_pkg::axil_rsp_t bus_rsp,
    // Sources from the rest of the device.
    input  wire gpio_sel_pkg::slot_sig_t slot,
    input  wire logic                   sleep,
    input  wire logic                   int_x,
    input  wire logic                   int_y,
    input  wire logic [3:0]             led_amp_en,
    input  wire logic                   osc_full,
    input  wire logic                   osc_div32,
    input  wire logic                   osc_div64,
    input  wire logic                   low_osc,
    input  wire logic                   period_tick,
    // Two-way pins.
    input  wire logic [3:0]             pin_in,
    output logic      [3:0]             pin_out,
    output logic      [3:0]             pin_oe,
    // Events to the time slot engine and the stamp counter.
    output logic                        stamp_capture,
    output logic                        sample_start
);
    import gpio_sel_pkg::*;

    state_t st;
    state_t next_st;
    logic   stamp_edge;
    logic   sync_edge;
    logic   sw_arm;
    logic   wr_go;
    logic [3:0] pin_levels;

    // One decoder serves all four pins so their code sets cannot drift apart.
    function automatic logic source_of(input logic [6:0] code);
        logic [11:0] vec;
        logic        pattern;
        vec = 12'h000;
        pattern = 1'b0;
        unique case (code[6:4])
            `GROUP_SLOT_ACTIVE: vec = slot.active;
            `GROUP_LED_PULSE:   vec = slot.led_pulse;
            `GROUP_MOD_PULSE:   vec = slot.mod_pulse;
            `GROUP_DATA_CYCLE:  vec = slot.data_cycle;
            default:            vec = 12'h000;
        endcase
        // Sleep forces the idle level even if a flagged slot still shows active.
        pattern = sleep ? st.slot_idle_level :
                  (|(slot.active & st.per_slot_pin_flag)) ? 1'b1 :
                  st.slot_idle_level;
        if (code[6:4] >= `GROUP_SLOT_ACTIVE && code[6:4] <= `GROUP_DATA_CYCLE) begin
            if (code[3:0] < 4'hC) begin
                source_of = vec[code[3:0]];
            end else if (code[3:0] == `SLOT_ANY && code[6:4] != `GROUP_SLOT_ACTIVE) begin
                source_of = |vec;
            end else begin
                source_of = 1'b0;
            end
        end else if (code[6:3] == `GROUP_AMP && code[2] == 1'b0) begin
            source_of = led_amp_en[code[1:0]];
        end else begin
            unique case (code)
                `CODE_LOW:          source_of = 1'b0;
                `CODE_HIGH:         source_of = 1'b1;
                `CODE_INT_X:        source_of = int_x;
                `CODE_INT_Y:        source_of = int_y;
                `CODE_ANY_AMP:      source_of = |led_amp_en;
                `CODE_OSC_DIV64:    source_of = osc_div64;
                `CODE_SLOT_PATTERN: source_of = pattern;
                `CODE_SLEEP:        source_of = sleep;
                `CODE_LOW_OSC:      source_of = low_osc;
                `CODE_OSC_FULL:     source_of = osc_full;
                `CODE_OSC_DIV32:    source_of = osc_div32;
                default:            source_of = 1'b0;
            endcase
        end
    endfunction

    // Register read map; unused bits read zero.
    function automatic logic [31:0] read_of(input logic [9:0] idx);
        unique case (idx)
            `IDX_PIN0_PIN1:     read_of = {16'h0000, 1'b0, st.pin_output_source[1],
                                           1'b0, st.pin_output_source[0]};
            `IDX_PIN2_PIN3:     read_of = {16'h0000, 1'b0, st.pin_output_source[3],
                                           1'b0, st.pin_output_source[2]};
            `IDX_PIN_LEVELS:    read_of = {28'h0000000, pin_levels};
            `IDX_SYNC_STAMP:    read_of = {23'h000000, st.slot_idle_level,
                                           st.stamp_edge_invert, st.stamp_always_armed,
                                           st.stamp_pin_select, 1'b0,
                                           st.outside_trigger_enable,
                                           st.outside_trigger_pin_select};
            `IDX_SLOT_FLAGS:    read_of = {20'h00000, st.per_slot_pin_flag};
            `IDX_STAMP_REQUEST: read_of = {31'h00000000, st.stamp_capture_request};
            `IDX_PIN_DIRECTION: read_of = {24'h000000, st.pin_direction};
            default:            read_of = 32'h00000000;
        endcase
    endfunction

    function automatic logic mapped(input logic [9:0] idx);
        mapped = (idx >= `IDX_PIN0_PIN1 && idx <= `IDX_SYNC_STAMP) ||
                 (idx >= `IDX_SLOT_FLAGS && idx <= `IDX_PIN_DIRECTION);
    endfunction

    // Readback only shows pins whose input enable is set.
    assign pin_levels = pin_in & st.pin_direction[7:4];
    // Pin inputs are synchronous, so one stored copy is enough to find edges.
    assign stamp_edge = st.stamp_edge_invert ?
        (st.pin_prev[st.stamp_pin_select] & ~pin_in[st.stamp_pin_select]) :
        (~st.pin_prev[st.stamp_pin_select] & pin_in[st.stamp_pin_select]);
    assign sync_edge = ~st.pin_prev[st.outside_trigger_pin_select] &
                       pin_in[st.outside_trigger_pin_select];
    assign wr_go  = st.aw_held & st.w_held;
    assign sw_arm = wr_go && st.aw_index == `IDX_STAMP_REQUEST &&
                    st.w_strb[0] && st.w_data[0];

    // Next-state logic: pins, triggers and the bus slave.
    always_comb begin
        next_st = st;
        for (int p = 0; p < 4; p++) begin
            next_st.pin_drive[p] = source_of(st.pin_output_source[p]);
        end
        next_st.pin_prev = pin_in;
        next_st.stamp_capture = stamp_edge & st.stamp_capture_request;
        // A software arm in the capture cycle wins over the automatic clear.
        if (stamp_edge && st.stamp_capture_request && !st.stamp_always_armed) begin
            next_st.stamp_capture_request = 1'b0;
        end
        if (sw_arm) begin
            next_st.stamp_capture_request = 1'b1;
        end
        next_st.sample_start = st.outside_trigger_enable ? sync_edge : period_tick;
        // Address and data are taken independently; the write runs once both are held.
        if (bus_req.awvalid && bus_rsp.awready) begin
            next_st.aw_held  = 1'b1;
            next_st.aw_index = bus_req.awaddr[11:2];
        end
        if (bus_req.wvalid && bus_rsp.wready) begin
            next_st.w_held = 1'b1;
            next_st.w_data = bus_req.wdata;
            next_st.w_strb = bus_req.wstrb;
        end
        if (wr_go) begin
            next_st.aw_held = 1'b0;
            next_st.w_held  = 1'b0;
            next_st.bvalid  = 1'b1;
            next_st.bresp   = mapped(st.aw_index) ? `RESP_OKAY : `RESP_SLVERR;
            unique case (st.aw_index)
                `IDX_PIN0_PIN1: begin
                    if (st.w_strb[0]) next_st.pin_output_source[0] = st.w_data[6:0];
                    if (st.w_strb[1]) next_st.pin_output_source[1] = st.w_data[14:8];
                end
                `IDX_PIN2_PIN3: begin
                    if (st.w_strb[0]) next_st.pin_output_source[2] = st.w_data[6:0];
                    if (st.w_strb[1]) next_st.pin_output_source[3] = st.w_data[14:8];
                end
                `IDX_SYNC_STAMP: begin
                    if (st.w_strb[1]) next_st.slot_idle_level = st.w_data[`FLD_IDLE_LEVEL];
                    if (st.w_strb[0]) begin
                        next_st.stamp_edge_invert  = st.w_data[`FLD_EDGE_INVERT];
                        next_st.stamp_always_armed = st.w_data[`FLD_ALWAYS_ARMED];
                        next_st.stamp_pin_select   = st.w_data[`FLD_STAMP_PIN_LSB +: 2];
                        next_st.outside_trigger_enable = st.w_data[`FLD_SYNC_ENABLE];
                        next_st.outside_trigger_pin_select =
                            st.w_data[`FLD_SYNC_PIN_LSB +: 2];
                    end
                end
                `IDX_SLOT_FLAGS: begin
                    if (st.w_strb[0]) next_st.per_slot_pin_flag[7:0]  = st.w_data[7:0];
                    if (st.w_strb[1]) next_st.per_slot_pin_flag[11:8] = st.w_data[11:8];
                end
                `IDX_PIN_DIRECTION: begin
                    if (st.w_strb[0]) next_st.pin_direction = st.w_data[7:0];
                end
                default: begin
                end
            endcase
        end
        if (st.bvalid && bus_req.bready) begin
            next_st.bvalid = 1'b0;
        end
        if (st.rvalid && bus_req.rready) begin
            next_st.rvalid = 1'b0;
        end
        if (bus_req.arvalid && bus_rsp.arready) begin
            next_st.rvalid = 1'b1;
            next_st.rdata  = read_of(bus_req.araddr[11:2]);
            next_st.rresp  = mapped(bus_req.araddr[11:2]) ? `RESP_OKAY : `RESP_SLVERR;
        end
    end

    // All state resets to constants only.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st <= '0;
            st.pin_output_source <= {4{`RST_SELECT}};
            st.pin_direction     <= `RST_DIRECTION;
        end else begin
            st <= next_st;
        end
    end

    // Ready terms stay combinational; a held word blocks a second one until the answer.
    always_comb begin
        bus_rsp.awready = !st.aw_held && !st.bvalid;
        bus_rsp.wready  = !st.w_held && !st.bvalid;
        bus_rsp.bvalid  = st.bvalid;
        bus_rsp.bresp   = st.bresp;
        bus_rsp.arready = !st.rvalid;
        bus_rsp.rvalid  = st.rvalid;
        bus_rsp.rdata   = st.rdata;
        bus_rsp.rresp   = st.rresp;
    end

    // Pins and event pulses come straight from flip-flops.
    assign pin_out       = st.pin_drive;
    assign pin_oe        = st.pin_direction[3:0];
    assign stamp_capture = st.stamp_capture;
    assign sample_start  = st.sample_start;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence armed_edge_s;
        stamp_edge && st.stamp_capture_request && !sw_arm;
    endsequence
    sequence capture_done_s;
        st.stamp_capture ##0 (st.stamp_capture_request == $past(st.stamp_always_armed));
    endsequence

    constant_high_a: assert property (
        st.pin_output_source[0] == 7'h01 |=> pin_out[0])
        else $error("Code 0x01 did not drive pin 0 high.");
    slot_k_mod_a: assert property (
        st.pin_output_source[1] == 7'h4A |=> pin_out[1] == $past(slot.mod_pulse[10]))
        else $error("Code 0x4A did not follow the slot K modulation pulse.");
    slot_l_data_a: assert property (
        st.pin_output_source[2] == 7'h5B |=> pin_out[2] == $past(slot.data_cycle[11]))
        else $error("Code 0x5B did not follow the slot L data cycle.");
    any_data_a: assert property (
        st.pin_output_source[3] == 7'h5F |=> pin_out[3] == |$past(slot.data_cycle))
        else $error("Code 0x5F did not mark a data cycle in any slot.");
    idle_sleep_a: assert property (
        st.pin_output_source[0] == 7'h10 && sleep |=> pin_out[0] == $past(st.slot_idle_level))
        else $error("Pattern code did not hold the idle level in sleep.");
    flag_active_a: assert property (
        st.pin_output_source[0] == 7'h10 && !sleep &&
        |(slot.active & st.per_slot_pin_flag) |=> pin_out[0])
        else $error("Pattern code did not drive one in a flagged slot.");
    level_read_a: assert property (
        bus_req.arvalid && bus_rsp.arready && bus_req.araddr[11:2] == `IDX_PIN_LEVELS
        |=> st.rvalid && st.rdata == {28'h0000000, $past(pin_in) & $past(st.pin_direction[7:4])})
        else $error("Pin level readback is wrong.");
    rising_stamp_a: assert property (
        !st.stamp_edge_invert && st.stamp_pin_select == 2'h0 && st.stamp_capture_request &&
        !st.pin_prev[0] && pin_in[0] |=> stamp_capture)
        else $error("Rising edge on pin 0 did not capture.");
    stamp_clear_a: assert property (
        armed_edge_s |=> capture_done_s)
        else $error("Capture request not cleared or kept as the armed bit says.");
    sync_pin3_a: assert property (
        st.outside_trigger_enable && st.outside_trigger_pin_select == 2'h3 &&
        !st.pin_prev[3] && pin_in[3] |=> sample_start)
        else $error("Rising edge on sync pin 3 did not start a sample.");
    period_start_a: assert property (
        !st.outside_trigger_enable |=> sample_start == $past(period_tick))
        else $error("Period tick did not start a sample with sync off.");
    // Falling edge and a pin other than 0, so a stuck edge or pin select shows up.
    falling_stamp_a: assert property (
        st.stamp_edge_invert && st.stamp_capture_request && st.pin_prev[st.stamp_pin_select] &&
        !pin_in[st.stamp_pin_select] |=> stamp_capture)
        else $error("Falling edge on the stamp pin did not capture.");
    stamp_pin_two_a: assert property (
        !st.stamp_edge_invert && st.stamp_pin_select == 2'h2 && st.stamp_capture_request &&
        !st.pin_prev[2] && pin_in[2] |=> stamp_capture)
        else $error("Rising edge on stamp pin 2 did not capture.");
endmodule
`default_nettype wire

// file: dv/gpio_far_end.sv
// Purpose: Outside logic that drives the pin lines while the block leaves them undriven.
// Assumes: Called just after a rising clock edge.
// Notes:   Each level is held four clocks so that both edges are seen by the sampler.
`timescale 1ns/10ps
`default_nettype none
module gpio_far_end (
    // Clock.
    input  wire logic       clk,
    // Far side drive of the pins.
    output var  logic [3:0] far_drv
);
    // Lines rest low until a test asks for activity.
    initial far_drv = 4'h0;
    // A short hold would let an edge slip between two samples, so levels stay put.
    task automatic pulse(input logic [1:0] p);
        far_drv[p] <= 1'b1;
        repeat (4) @(posedge clk);
        far_drv[p] <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    // Static levels for readback.
    task automatic hold(input logic [3:0] v);
        far_drv <= v;
        @(posedge clk);
    endtask
endmodule
`default_nettype wire

// file: dv/gpio_output_select_sync_timestamp_test.sv
// Purpose: Self-checking bench of the pin select, readback, stamp and trigger block.
// Assumes: Register access over AXI4-Lite with ready levels held high for answers.
// Notes:   Expected pin levels are worked out from the bench's own stimulus.
`timescale 1ns/10ps
`include "gpio_sel_consts.svh"
`default_nettype none
module gpio_output_select_sync_timestamp_test;
    import gpio_sel_pkg::*;
    logic       clk = 1'b0;
    logic       reset_n = 1'b0;
    axil_req_t  req;
    axil_rsp_t  rsp;
    slot_sig_t  slot_s = '0;
    logic       sleep_s = 1'b0;
    logic       int_x_s = 1'b0;
    logic       int_y_s = 1'b0;
    logic       tick = 1'b0;
    logic [3:0] amp_s = 4'h0;
    logic [3:0] osc_s = 4'h0;
    logic [3:0] pin_out;
    logic [3:0] pin_oe;
    logic [3:0] far_drv;
    logic       stamp_capture;
    logic       sample_start;
    logic [1:0] sel = 2'h0;
    logic       cap_lvl = 1'b0;
    int         caps = 0;
    int         starts = 0;
    int         miscompares = 0;
    int         checked = 0;
    // The wire level is whoever drives it: the block when enabled, else the far side.
    wire logic [3:0] pin_wire = (pin_oe & pin_out) | (~pin_oe & far_drv);

    gpio_sel_top dut_u (.clk(clk), .reset_n(reset_n), .bus_req(req), .bus_rsp(rsp),
        .slot(slot_s), .sleep(sleep_s), .int_x(int_x_s), .int_y(int_y_s),
        .led_amp_en(amp_s), .osc_full(osc_s[0]), .osc_div32(osc_s[1]), .osc_div64(osc_s[2]),
        .low_osc(osc_s[3]), .period_tick(tick), .pin_in(pin_wire), .pin_out(pin_out),
        .pin_oe(pin_oe), .stamp_capture(stamp_capture), .sample_start(sample_start));
    gpio_far_end far_u (.clk(clk), .far_drv(far_drv));

    // Clock of 100 ns period.
    always #50 clk = ~clk;
    // Tally event pulses; the pin level at a capture tells which edge fired.
    always @(posedge clk) begin
        if (stamp_capture === 1'b1) begin
            caps++;
            cap_lvl = pin_wire[sel];
        end
        if (sample_start === 1'b1) starts++;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Address and data are offered together and each is dropped once taken.
    task automatic wr(input logic [9:0] idx, input logic [15:0] d, input logic [1:0] er);
        req.awaddr <= {idx, 2'b00};
        req.wdata <= {16'h0000, d};
        req.wstrb <= 4'hF;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (rsp.awready) req.awvalid <= 1'b0;
            if (rsp.wready) req.wvalid <= 1'b0;
        end while (rsp.bvalid !== 1'b1);
        chk({30'h0, rsp.bresp}, {30'h0, er});
    endtask
    task automatic rd(input logic [9:0] idx, input logic [31:0] ed, input logic [1:0] er);
        req.araddr <= {idx, 2'b00};
        req.arvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (rsp.arready) req.arvalid <= 1'b0;
        end while (rsp.rvalid !== 1'b1);
        chk(rsp.rdata, ed);
        chk({30'h0, rsp.rresp}, {30'h0, er});
    endtask
    // Pin level that a select code should give for the present stimulus.
    function automatic logic exp_pin(input logic [6:0] c);
        logic [11:0] v;
        v = (c[6:4] == 3'h2) ? slot_s.active : (c[6:4] == 3'h3) ? slot_s.led_pulse :
            (c[6:4] == 3'h4) ? slot_s.mod_pulse :
            (c[6:4] == 3'h5) ? slot_s.data_cycle : 12'h000;
        case (c)
            7'h01: return 1'b1;
            7'h02: return int_x_s;
            7'h03: return int_y_s;
            7'h08, 7'h09, 7'h0A, 7'h0B: return amp_s[c[1:0]];
            7'h0C: return |amp_s;
            7'h0F: return osc_s[2];
            7'h16: return osc_s[3];
            7'h17: return osc_s[0];
            7'h18: return osc_s[1];
            7'h3F, 7'h4F, 7'h5F: return |v;
            default: return (c[6:4] >= 3'h2 && c[6:4] <= 3'h5 && c[3:0] < 4'hC) ?
                            v[c[3:0]] : 1'b0;
        endcase
    endfunction
    task automatic give_verdict;
        if (miscompares == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Watchdog well beyond the few thousand cycles the tests need.
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        give_verdict;
    end
    // Main sequence.
    initial begin
        req = '0;
        req.bready = 1'b1;
        req.rready = 1'b1;
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        rd(`IDX_PIN2_PIN3, 32'h0, `RESP_OKAY);
        rd(`IDX_SYNC_STAMP, 32'h0, `RESP_OKAY);
        wr(`IDX_PIN2_PIN3, 16'hFFFF, `RESP_OKAY);
        rd(`IDX_PIN2_PIN3, 32'h7F7F, `RESP_OKAY);
        wr(`IDX_SYNC_STAMP, 16'hFFFF, `RESP_OKAY);
        rd(`IDX_SYNC_STAMP, 32'h01F7, `RESP_OKAY);
        wr(10'h3FF, 16'h1234, `RESP_SLVERR);
        rd(10'h3FF, 32'h0, `RESP_SLVERR);
        wr(`IDX_SYNC_STAMP, 16'h0000, `RESP_OKAY);
        wr(`IDX_PIN_DIRECTION, 16'h000F, `RESP_OKAY);
        // Every code on all four pins under two opposite stimulus sets.
        for (int k = 0; k < 256; k++) begin
            int_x_s <= k[7];
            int_y_s <= ~k[7];
            slot_s.mod_pulse <= k[7] ? 12'h800 : 12'h400;
            slot_s.data_cycle <= k[7] ? 12'h800 : 12'h005;
            slot_s.active <= k[7] ? 12'h010 : 12'h000;
            slot_s.led_pulse <= k[7] ? 12'h400 : 12'h001;
            amp_s <= k[7] ? 4'h6 : 4'h0;
            osc_s <= k[7] ? 4'h5 : 4'hA;
            wr(`IDX_PIN0_PIN1, {1'b0, k[6:0], 1'b0, k[6:0]}, `RESP_OKAY);
            wr(`IDX_PIN2_PIN3, {1'b0, k[6:0], 1'b0, k[6:0]}, `RESP_OKAY);
            repeat (2) @(posedge clk);
            chk({28'h0, pin_wire}, {28'h0, {4{exp_pin(k[6:0])}}});
        end
        // Slot pattern: flagged slot, unflagged slot, idle level, sleep.
        wr(`IDX_SLOT_FLAGS, 16'h0002, `RESP_OKAY);
        wr(`IDX_PIN0_PIN1, 16'h1010, `RESP_OKAY);
        wr(`IDX_PIN2_PIN3, 16'h1010, `RESP_OKAY);
        for (int k = 0; k < 4; k++) begin
            slot_s.active <= (k == 1) ? 12'h001 : ((k == 2) ? 12'h000 : 12'h002);
            sleep_s <= (k == 3);
            wr(`IDX_SYNC_STAMP, {7'h0, k == 2, 8'h00}, `RESP_OKAY);
            repeat (2) @(posedge clk);
            chk({28'h0, pin_wire}, {28'h0, {4{k == 0 || k == 2}}});
        end
        wr(`IDX_PIN_DIRECTION, 16'h0050, `RESP_OKAY);
        far_u.hold(4'hF);
        rd(`IDX_PIN_LEVELS, 32'h0005, `RESP_OKAY);
        far_u.hold(4'h0);
        wr(`IDX_PIN_DIRECTION, 16'h00F0, `RESP_OKAY);
        // Each pin, both edges, armed or not, outside trigger on or off.
        for (int k = 0; k < 16; k++) begin
            sel = k[1:0];
            wr(`IDX_SYNC_STAMP, {8'h0, k[2], k[3], k[1:0], 1'b0, k[2] ^ k[3], k[1:0]},
               `RESP_OKAY);
            wr(`IDX_STAMP_REQUEST, 16'h0001, `RESP_OKAY);
            caps = 0;
            starts = 0;
            far_u.pulse(sel);
            tick <= 1'b1;
            @(posedge clk);
            tick <= 1'b0;
            far_u.pulse(sel);
            chk(32'(caps), k[3] ? 32'd2 : 32'd1);
            chk({31'h0, cap_lvl}, {31'h0, ~k[2]});
            chk(32'(starts), (k[2] ^ k[3]) ? 32'd2 : 32'd1);
            rd(`IDX_STAMP_REQUEST, {31'h0, k[3]}, `RESP_OKAY);
        end
        give_verdict;
    end
endmodule
`default_nettype wire
